// >>> uhie_pkg.sv
// Constants, register layout and carrier types of the host event flag and gate logic.
// Assumes a plain register port on a single 40 MHz clock.
package uhie_pkg;
  localparam logic [31:0] UHIE_FLAGS_ADDR = 32'h9010100c;
  localparam logic [31:0] UHIE_GATE_ADDR = 32'h90101010;
  localparam int UHIE_MASTER_BIT = 31;
  localparam int UHIE_OWN_BIT = 30;
  localparam int UHIE_ROOT_BIT = 6;
  localparam int UHIE_FRAME_OVF_BIT = 5;
  localparam int UHIE_FATAL_BIT = 4;
  localparam int UHIE_RESUME_BIT = 3;
  localparam int UHIE_SOF_BIT = 2;
  localparam int UHIE_DONE_BIT = 1;
  localparam int UHIE_OVERRUN_BIT = 0;
  localparam logic [31:0] UHIE_FLAG_MASK = 32'h4000007f;
  localparam logic [31:0] UHIE_GATE_MASK = 32'hc000007f;
  localparam logic [31:0] UHIE_RESET_VAL = 32'h00000000;
  localparam logic [1:0] UHIE_CNT_RESET = 2'h0;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } uhie_bus_req_t;

  typedef struct packed {
    logic ownership_request_bit;
    logic root_hub_change;
    logic frame_counter_msb;
    logic shared_frame_updated;
    logic system_error;
    logic resume_signaling;
    logic sw_resume_command;
    logic frame_start;
    logic done_head_written;
    logic schedule_overrun;
  } uhie_events_t;
endpackage : uhie_pkg

// >>> uhie_top.sv
// Event flag register, set-only gate register and level interrupt request.
// Assumes event inputs synchronous to ref_clk_in, one-cycle pulses except levels named so.
`timescale 1ns/100ps
module uhie_top import uhie_pkg::*; #(
  parameter bit HAS_MGMT_INT = 1'b1
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire uhie_bus_req_t bus_in,
  input wire uhie_events_t ev_in,
  output logic [31:0] rdata_out,
  output logic irq_out,
  output logic mgmt_irq_out,
  output logic halt_out,
  output logic [1:0] overrun_counter_out
);
  //////////////////////////////////////////////////////////////////////////////
  logic rst_sync1_q;
  logic rst_n_q;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_n_q <= rst_sync1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  logic [31:0] flags_q;
  logic [31:0] flags_d;
  logic [31:0] gate_q;
  logic [31:0] set_v;
  logic [31:0] clr_v;
  logic msb_q;
  logic resume_q;
  logic own_req_q;
  logic wr_flags;
  logic wr_gate;

  assign wr_flags = bus_in.wr && (bus_in.addr == UHIE_FLAGS_ADDR);
  assign wr_gate = bus_in.wr && (bus_in.addr == UHIE_GATE_ADDR);

  always_comb begin
    set_v = UHIE_RESET_VAL;
    set_v[UHIE_OWN_BIT] = ev_in.ownership_request_bit && !own_req_q && HAS_MGMT_INT;
    set_v[UHIE_ROOT_BIT] = ev_in.root_hub_change;
    set_v[UHIE_FRAME_OVF_BIT] = ev_in.shared_frame_updated && (ev_in.frame_counter_msb != msb_q);
    set_v[UHIE_FATAL_BIT] = ev_in.system_error;
    set_v[UHIE_RESUME_BIT] = ev_in.resume_signaling && !resume_q && !ev_in.sw_resume_command;
    set_v[UHIE_SOF_BIT] = ev_in.frame_start && ev_in.shared_frame_updated;
    set_v[UHIE_DONE_BIT] = ev_in.done_head_written;
    set_v[UHIE_OVERRUN_BIT] = ev_in.schedule_overrun && ev_in.shared_frame_updated;
    clr_v = wr_flags ? bus_in.wdata : UHIE_RESET_VAL;
    // Set wins over a clear in the same cycle so no event is lost.
    flags_d = ((flags_q & ~clr_v) | set_v) & UHIE_FLAG_MASK;
    if (!HAS_MGMT_INT) begin
      flags_d[UHIE_OWN_BIT] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flags_q <= UHIE_RESET_VAL;
      msb_q <= 1'b0;
      resume_q <= 1'b0;
      own_req_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      if (ev_in.shared_frame_updated) begin
        msb_q <= ev_in.frame_counter_msb;
      end
      resume_q <= ev_in.resume_signaling;
      own_req_q <= ev_in.ownership_request_bit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gate_q <= UHIE_RESET_VAL;
    end else if (wr_gate) begin
      gate_q <= gate_q | (bus_in.wdata & UHIE_GATE_MASK);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      overrun_counter_out <= UHIE_CNT_RESET;
    end else if (set_v[UHIE_OVERRUN_BIT]) begin
      overrun_counter_out <= overrun_counter_out + 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Master gate touches only the request outputs, never list processing.
  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_out <= 1'b0;
      mgmt_irq_out <= 1'b0;
      halt_out <= 1'b0;
    end else begin
      irq_out <= gate_q[UHIE_MASTER_BIT] && |(flags_d & gate_q & UHIE_FLAG_MASK);
      mgmt_irq_out <= gate_q[UHIE_MASTER_BIT] && flags_d[UHIE_OWN_BIT] && gate_q[UHIE_OWN_BIT];
      halt_out <= flags_d[UHIE_FATAL_BIT];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_out <= UHIE_RESET_VAL;
    end else if (bus_in.rd && bus_in.addr == UHIE_FLAGS_ADDR) begin
      rdata_out <= flags_q;
    end else if (bus_in.rd && bus_in.addr == UHIE_GATE_ADDR) begin
      rdata_out <= gate_q;
    end else begin
      rdata_out <= UHIE_RESET_VAL;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  sequence clr_write_s;
    wr_flags && !ev_in.done_head_written && bus_in.wdata[UHIE_DONE_BIT];
  endsequence

  done_set_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    ev_in.done_head_written |=> flags_q[UHIE_DONE_BIT]) else $error("done flag not set");
  clr_done_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    clr_write_s |=> !flags_q[UHIE_DONE_BIT]) else $error("done flag not cleared");
  hold_flag_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    flags_q[UHIE_ROOT_BIT] && !(wr_flags && bus_in.wdata[UHIE_ROOT_BIT]) |=> flags_q[UHIE_ROOT_BIT])
    else $error("flag lost");
  irq_level_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    irq_out == ($past(gate_q[UHIE_MASTER_BIT]) && |(flags_q & $past(gate_q) & UHIE_FLAG_MASK))) else $error("irq wrong");
  gate_set_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    wr_gate |=> (gate_q & $past(bus_in.wdata & UHIE_GATE_MASK)) == $past(bus_in.wdata & UHIE_GATE_MASK))
    else $error("gate bit not set");
  gate_keep_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    ($past(gate_q) & ~gate_q) == 32'h0) else $error("gate bit dropped");
  ovf_count_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    set_v[UHIE_OVERRUN_BIT] |=> overrun_counter_out == $past(overrun_counter_out) + 2'h1)
    else $error("counter not bumped");
  sw_resume_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    ev_in.sw_resume_command && !flags_q[UHIE_RESUME_BIT] && !wr_flags |=> !flags_q[UHIE_RESUME_BIT])
    else $error("resume flag on sw resume");
  gate_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    bus_in.rd && bus_in.addr == UHIE_GATE_ADDR |=> rdata_out == $past(gate_q)) else $error("gate read wrong");

  //////////////////////////////////////////////////////////////////////////////
  // Event conditions as the flag logic sees them in one cycle.
  sequence own_rise_s;
    ev_in.ownership_request_bit && !own_req_q;
  endsequence

  sequence root_ev_s;
    ev_in.root_hub_change;
  endsequence

  sequence msb_flip_s;
    ev_in.shared_frame_updated && (ev_in.frame_counter_msb != msb_q);
  endsequence

  sequence fatal_s;
    ev_in.system_error;
  endsequence

  sequence resume_rise_s;
    ev_in.resume_signaling && !resume_q && !ev_in.sw_resume_command;
  endsequence

  sequence sof_s;
    ev_in.frame_start && ev_in.shared_frame_updated;
  endsequence

  sequence overrun_s;
    ev_in.schedule_overrun && ev_in.shared_frame_updated;
  endsequence

  //////////////////////////////////////////////////////////////////////////////
  // The request is registered, so it follows the flags of this cycle and the gate of the last one.
  irq_master_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    !$past(gate_q[UHIE_MASTER_BIT])
    |-> !irq_out)
    else $error("irq without master gate");

  irq_none_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    (flags_q & $past(gate_q) & UHIE_FLAG_MASK) == 32'h0
    |-> !irq_out)
    else $error("irq without gated flag");

  irq_high_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    $past(gate_q[UHIE_MASTER_BIT]) && |(flags_q & $past(gate_q) & UHIE_FLAG_MASK)
    |-> irq_out)
    else $error("irq level dropped");

  mgmt_needs_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    mgmt_irq_out
    |-> flags_q[UHIE_OWN_BIT] && $past(gate_q[UHIE_MASTER_BIT]))
    else $error("mgmt irq without cause");

  mgmt_raise_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    $past(gate_q[UHIE_MASTER_BIT] && gate_q[UHIE_OWN_BIT]) && flags_q[UHIE_OWN_BIT]
    |-> mgmt_irq_out)
    else $error("mgmt irq missing");

  own_set_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    own_rise_s
    |=> flags_q[UHIE_OWN_BIT] == HAS_MGMT_INT)
    else $error("ownership flag not set");

  own_tied_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    flags_q[UHIE_OWN_BIT]
    |-> HAS_MGMT_INT)
    else $error("ownership flag not tied low");

  root_set_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    root_ev_s
    |=> flags_q[UHIE_ROOT_BIT])
    else $error("root hub flag not set");

  fno_set_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    msb_flip_s
    |=> flags_q[UHIE_FRAME_OVF_BIT])
    else $error("frame overflow flag not set");

  fno_wait_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    !flags_q[UHIE_FRAME_OVF_BIT] && !ev_in.shared_frame_updated
    |=> !flags_q[UHIE_FRAME_OVF_BIT])
    else $error("frame overflow before copy");

  fatal_set_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    fatal_s
    |=> flags_q[UHIE_FATAL_BIT])
    else $error("fatal flag not set");

  halt_track_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    halt_out == flags_q[UHIE_FATAL_BIT])
    else $error("halt does not follow fatal flag");

  resume_set_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    resume_rise_s
    |=> flags_q[UHIE_RESUME_BIT])
    else $error("resume flag not set");

  resume_quiet_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    !flags_q[UHIE_RESUME_BIT] && !ev_in.resume_signaling
    |=> !flags_q[UHIE_RESUME_BIT])
    else $error("resume flag without signaling");

  sof_set_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    sof_s
    |=> flags_q[UHIE_SOF_BIT])
    else $error("frame start flag not set");

  sof_wait_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    !flags_q[UHIE_SOF_BIT] && !ev_in.shared_frame_updated
    |=> !flags_q[UHIE_SOF_BIT])
    else $error("frame start flag before copy");

  ovr_set_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    overrun_s
    |=> flags_q[UHIE_OVERRUN_BIT])
    else $error("overrun flag not set");

  ovr_bump_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    overrun_s
    |=> overrun_counter_out != $past(overrun_counter_out))
    else $error("overrun counter stuck");

  ovr_still_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    !(ev_in.schedule_overrun && ev_in.shared_frame_updated)
    |=> $stable(overrun_counter_out))
    else $error("overrun counter moved");

  ovr_wrap_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    ev_in.schedule_overrun && ev_in.shared_frame_updated && overrun_counter_out == 2'h3
    |=> overrun_counter_out == 2'h0)
    else $error("overrun counter did not wrap");

  //////////////////////////////////////////////////////////////////////////////
  // Software may only clear flags, and only set gate bits.
  clr_root_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    wr_flags && bus_in.wdata[UHIE_ROOT_BIT] && !ev_in.root_hub_change
    |=> !flags_q[UHIE_ROOT_BIT])
    else $error("root hub flag not cleared");

  no_sw_set_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    wr_flags && !flags_q[UHIE_FATAL_BIT] && !ev_in.system_error
    |=> !flags_q[UHIE_FATAL_BIT])
    else $error("write set a flag");

  flag_resv_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    (flags_q & ~UHIE_FLAG_MASK) == 32'h0)
    else $error("reserved flag bit set");

  gate_resv_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    (gate_q & ~UHIE_GATE_MASK) == 32'h0)
    else $error("reserved gate bit set");

  gate_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    !wr_gate
    |=> $stable(gate_q))
    else $error("gate changed without write");

  done_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    flags_q[UHIE_DONE_BIT] && !wr_flags
    |=> flags_q[UHIE_DONE_BIT])
    else $error("done flag lost");

  own_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    flags_q[UHIE_OWN_BIT] && !wr_flags
    |=> flags_q[UHIE_OWN_BIT])
    else $error("ownership flag lost");

  flags_steady_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    !wr_flags && set_v == 32'h0
    |=> $stable(flags_q))
    else $error("flags moved on gate activity");

  //////////////////////////////////////////////////////////////////////////////
  // Read data stand for one cycle only and are zero otherwise.
  flags_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    bus_in.rd && bus_in.addr == UHIE_FLAGS_ADDR
    |=> rdata_out == $past(flags_q))
    else $error("flag read wrong");

  idle_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
    !bus_in.rd
    |=> rdata_out == 32'h0)
    else $error("read data without read");
endmodule : uhie_top

// >>> uhie_ev_src.sv
// Event source model for the list processor, frame counter and root hub.
// Assumes a ten-bit request vector in the field order of the event struct.
`timescale 1ns/100ps
module uhie_ev_src import uhie_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic [9:0] req_in,
  output uhie_events_t ev_out
);
  // The frame copy strobe travels with frame start, overrun and the top counter bit.
  always_ff @(posedge ref_clk_in) begin
    ev_out <= uhie_events_t'(req_in);
  end
endmodule : uhie_ev_src

// >>> testbench.sv
// Self-checking bench for the event flag and gate logic.
// Assumes the event source model and a 40 MHz clock.
`timescale 1ns/100ps
module testbench import uhie_pkg::*; ;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  uhie_bus_req_t bus = '0;
  logic [9:0] req = '0;
  logic [9:0] lvl = '0;
  uhie_events_t ev;
  logic [31:0] rdata;
  logic irq, mirq, halt;
  logic [1:0] cnt;
  int error_cnt = 0;
  int n_checks = 0;
  logic [9:0] evs [5] = '{10'h002, 10'h044, 10'h041, 10'h020, 10'h100};
  logic [31:0] exps [5] = '{32'h02, 32'h04, 32'h01, 32'h10, 32'h40};
  always #12.5 ref_clk_in = ~ref_clk_in;
  uhie_ev_src i_src (.ref_clk_in(ref_clk_in), .req_in(req), .ev_out(ev));
  uhie_top i_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus_in(bus), .ev_in(ev), .rdata_out(rdata),
    .irq_out(irq), .mgmt_irq_out(mirq), .halt_out(halt), .overrun_counter_out(cnt));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk_in) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk_in) bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge ref_clk_in) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk_in) bus.rd <= 1'b0;
    #1 chk("rdata", exp, rdata);
  endtask : rd
  task automatic fire(input logic [9:0] v);
    @(posedge ref_clk_in) req <= lvl | v;
    @(posedge ref_clk_in) req <= lvl;
    @(posedge ref_clk_in);
    #1;
  endtask : fire
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    rd(UHIE_FLAGS_ADDR, 32'h0);
    rd(UHIE_GATE_ADDR, 32'h0);
    fire(10'h100);
    chk("irq", 32'h0, 32'(irq));
    rd(UHIE_FLAGS_ADDR, 32'h40);
    wr(UHIE_GATE_ADDR, 32'h40);
    rd(UHIE_GATE_ADDR, 32'h40);
    chk("irq", 32'h0, 32'(irq));
    wr(UHIE_GATE_ADDR, 32'h80000000);
    rd(UHIE_GATE_ADDR, 32'h80000040);
    chk("irq", 32'h1, 32'(irq));
    wr(UHIE_FLAGS_ADDR, 32'h0);
    rd(UHIE_FLAGS_ADDR, 32'h40);
    chk("irq", 32'h1, 32'(irq));
    wr(UHIE_FLAGS_ADDR, 32'h40);
    rd(UHIE_FLAGS_ADDR, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    wr(UHIE_GATE_ADDR, 32'hffffffff);
    rd(UHIE_GATE_ADDR, 32'hc000007f);
    foreach (evs[i]) begin
      fire(evs[i]);
      if (i == 3) chk("halt", 32'h1, 32'(halt));
      rd(UHIE_FLAGS_ADDR, exps[i]);
      wr(UHIE_FLAGS_ADDR, exps[i]);
    end
    chk("halt", 32'h0, 32'(halt));
    repeat (4) fire(10'h041);
    chk("count", 32'h1, 32'(cnt));
    rd(UHIE_FLAGS_ADDR, 32'h1);
    wr(UHIE_FLAGS_ADDR, 32'h1);
    lvl[7] = 1'b1;
    fire(10'h040);
    rd(UHIE_FLAGS_ADDR, 32'h20);
    wr(UHIE_FLAGS_ADDR, 32'h20);
    lvl[4:3] = 2'h3;
    fire(10'h0);
    rd(UHIE_FLAGS_ADDR, 32'h0);
    lvl[4:3] = 2'h0;
    fire(10'h0);
    lvl[4] = 1'b1;
    fire(10'h0);
    rd(UHIE_FLAGS_ADDR, 32'h08);
    wr(UHIE_FLAGS_ADDR, 32'h08);
    lvl[9] = 1'b1;
    fire(10'h0);
    rd(UHIE_FLAGS_ADDR, 32'h40000000);
    chk("mgmt", 32'h1, 32'(mirq));
    summarize();
  end
endmodule : testbench
